// ### hdl/vcr_pkg.sv
package vcr_pkg;
    // Extended configuration space offsets
    localparam logic [11:0] STATUS_OFFSET = 12'h16A;
    localparam logic [11:0] CAP_OFFSET = 12'h16C;
    // Reset values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [31:0] CAP_RESET = 32'h077F0011;
    // Status field positions
    localparam int STATUS_DIRTY_BIT = 0;
    localparam int STATUS_PENDING_BIT = 1;
    // Capability field values
    localparam logic [7:0] CAP_ARB_TABLE_LOCATION = 8'h07;
    localparam logic [6:0] CAP_TIME_SLOT_COUNT = 7'h7F;
    localparam logic [7:0] CAP_ARB_SCHEME_SUPPORT = 8'h11;
    localparam logic [0:0] CAP_SNOOP_REFUSAL = 1'h0;
    localparam logic [0:0] CAP_AS_ONLY_FLAG = 1'h0;
    // Negotiation states
    typedef enum logic [1:0] {
        VCR_IDLE = 2'b00,
        VCR_BUSY = 2'b01
    } vcr_state_e;
endpackage

// ### hdl/vcr_flag.sv
`timescale 1ns/1ns
`default_nettype none
// Sticky flag: set wins over clear
module vcr_flag (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_q;
    logic flag_d;

    // Set has priority so no modification is lost
    assign flag_d = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_q);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule
`default_nettype wire

// ### hdl/vcr_regs.sv
`timescale 1ns/1ns
`default_nettype none
module vcr_regs (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CFG_RD,
    input wire logic CFG_WR,
    input wire logic [11:0] CFG_ADDR,
    input wire logic [31:0] CFG_WDATA,
    input wire logic CHANNEL_ENABLE_WR,
    input wire logic CHANNEL_ENABLE_DIS,
    input wire logic NEGOTIATION_DONE,
    input wire logic ARB_TABLE_WRITE,
    input wire logic REFRESH_REQUEST,
    input wire logic REFRESH_DONE,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RVALID,
    output logic NEGOTIATION_PENDING,
    output logic ARB_TABLE_DIRTY
);
    vcr_pkg::vcr_state_e state_q;
    vcr_pkg::vcr_state_e state_d;
    logic refresh_armed_q;
    logic refresh_armed_d;
    logic dirty_clr;
    logic dirty;
    logic pending;
    logic start_neg;
    logic hit_status;
    logic hit_cap;
    logic [15:0] status_word;
    logic [31:0] cap_word;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic pend_out_q;
    logic dirty_out_q;
    logic cfg_wr_unused;
    logic [31:0] wdata_unused;

    // Writes have no effect on these read-only registers
    assign cfg_wr_unused = CFG_WR;
    assign wdata_unused = CFG_WDATA;

    // Enable or disable request restarts negotiation
    assign start_neg = CHANNEL_ENABLE_WR | CHANNEL_ENABLE_DIS;

    // Negotiation state; reset lands in busy for startup negotiation
    always_comb begin
        state_d = state_q;
        case (state_q)
            vcr_pkg::VCR_IDLE: begin
                if (start_neg) begin
                    state_d = vcr_pkg::VCR_BUSY;
                end
            end
            vcr_pkg::VCR_BUSY: begin
                if (NEGOTIATION_DONE && !start_neg) begin
                    state_d = vcr_pkg::VCR_IDLE;
                end
            end
            default: state_d = vcr_pkg::VCR_IDLE;
        endcase
    end

    assign pending = (state_q == vcr_pkg::VCR_BUSY);

    // Refresh must be requested before completion can clear dirty
    assign refresh_armed_d = REFRESH_REQUEST ? 1'b1 :
        (REFRESH_DONE ? 1'b0 : refresh_armed_q);
    assign dirty_clr = refresh_armed_q & REFRESH_DONE;

    vcr_flag u_dirty (
        .MCLK(MCLK),
        .RST(RST),
        .set_i(ARB_TABLE_WRITE),
        .clr_i(dirty_clr),
        .flag_o(dirty)
    );

    // Register images
    always_comb begin
        status_word = vcr_pkg::STATUS_RESET;
        status_word[vcr_pkg::STATUS_PENDING_BIT] = pending;
        status_word[vcr_pkg::STATUS_DIRTY_BIT] = dirty;
    end

    // Constant capability image, reserved bits zero
    assign cap_word = {vcr_pkg::CAP_ARB_TABLE_LOCATION,
        1'b0,
        vcr_pkg::CAP_TIME_SLOT_COUNT,
        vcr_pkg::CAP_SNOOP_REFUSAL,
        vcr_pkg::CAP_AS_ONLY_FLAG,
        6'h00,
        vcr_pkg::CAP_ARB_SCHEME_SUPPORT};

    // Address decode; unmapped offsets read zero
    assign hit_status = (CFG_ADDR == vcr_pkg::STATUS_OFFSET);
    assign hit_cap = (CFG_ADDR == vcr_pkg::CAP_OFFSET);
    assign rdata_d = hit_status ? {16'h0000, status_word} :
        (hit_cap ? cap_word : 32'h00000000);

    // Outputs registered, one cycle read latency
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= vcr_pkg::VCR_BUSY;
            refresh_armed_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
            pend_out_q <= 1'b0;
            dirty_out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            refresh_armed_q <= refresh_armed_d;
            rdata_q <= CFG_RD ? rdata_d : 32'h00000000;
            rvalid_q <= CFG_RD;
            pend_out_q <= pending;
            dirty_out_q <= dirty;
        end
    end

    assign CFG_RDATA = rdata_q;
    assign CFG_RVALID = rvalid_q;
    assign NEGOTIATION_PENDING = pend_out_q;
    assign ARB_TABLE_DIRTY = dirty_out_q;
endmodule
`default_nettype wire

// ### sim/vcr_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module vcr_regs_chk (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CFG_RD,
    input wire logic [11:0] CFG_ADDR,
    input wire logic CHANNEL_ENABLE_WR,
    input wire logic CHANNEL_ENABLE_DIS,
    input wire logic ARB_TABLE_WRITE,
    input wire logic REFRESH_DONE,
    input wire logic [31:0] CFG_RDATA,
    input wire logic NEGOTIATION_PENDING,
    input wire logic ARB_TABLE_DIRTY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Read requests, one per register
    sequence cap_rd_s;
        CFG_RD && CFG_ADDR == 12'h16C;
    endsequence
    sequence st_rd_s;
        CFG_RD && CFG_ADDR == 12'h16A;
    endsequence
    AST_TBL: assert property (cap_rd_s |=> CFG_RDATA[31:24] == 8'h07)
        else $error("table location wrong");
    AST_SLOTS: assert property (cap_rd_s |=> CFG_RDATA[22:16] == 7'h7F)
        else $error("slot count wrong");
    AST_SNP_AS: assert property (cap_rd_s |=> CFG_RDATA[15:14] == 2'h0)
        else $error("snoop or switching bit set");
    AST_RSV: assert property (cap_rd_s |=> !CFG_RDATA[23] && CFG_RDATA[13:8] == 6'h00)
        else $error("reserved cap bits set");
    AST_ARB: assert property (cap_rd_s |=> CFG_RDATA[7:0] == 8'h11)
        else $error("scheme field wrong");
    AST_ST_RSV: assert property (st_rd_s |=> CFG_RDATA[31:2] == 30'h0)
        else $error("reserved status bits set");
    // Output copy lags the status bit by one cycle
    AST_PEND: assert property (CHANNEL_ENABLE_WR || CHANNEL_ENABLE_DIS |-> ##2 NEGOTIATION_PENDING)
        else $error("pending not raised");
    AST_DIRTY: assert property (ARB_TABLE_WRITE |-> ##2 ARB_TABLE_DIRTY)
        else $error("dirty not set");
    AST_CLR: assert property ($fell(ARB_TABLE_DIRTY) |-> $past(REFRESH_DONE, 2))
        else $error("dirty cleared without refresh");
endmodule
bind vcr_regs vcr_regs_chk i_chk (.MCLK(MCLK), .RST(RST), .CFG_RD(CFG_RD),
    .CFG_ADDR(CFG_ADDR), .CHANNEL_ENABLE_WR(CHANNEL_ENABLE_WR),
    .CHANNEL_ENABLE_DIS(CHANNEL_ENABLE_DIS), .ARB_TABLE_WRITE(ARB_TABLE_WRITE),
    .REFRESH_DONE(REFRESH_DONE), .CFG_RDATA(CFG_RDATA),
    .NEGOTIATION_PENDING(NEGOTIATION_PENDING), .ARB_TABLE_DIRTY(ARB_TABLE_DIRTY));
`default_nettype wire

// ### sim/vcr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module vcr_regs_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [5:0] ev = 6'h00; // Enable, disable, done, table write, req, refreshed
    logic [31:0] rdata;
    logic rvalid;
    logic pend;
    logic dirty;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    always #5 mclk = ~mclk;
    vcr_regs i_vcr_regs (.MCLK(mclk), .RST(rst), .CFG_RD(rd), .CFG_WR(wr),
        .CFG_ADDR(addr), .CFG_WDATA(32'hFFFFFFFF), .CHANNEL_ENABLE_WR(ev[5]),
        .CHANNEL_ENABLE_DIS(ev[4]), .NEGOTIATION_DONE(ev[3]),
        .ARB_TABLE_WRITE(ev[2]), .REFRESH_REQUEST(ev[1]), .REFRESH_DONE(ev[0]),
        .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .NEGOTIATION_PENDING(pend),
        .ARB_TABLE_DIRTY(dirty));
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One-cycle event pulse, or an ignored write when w is set
    task automatic pulse(input logic [5:0] e, input logic w);
        ev = e;
        wr = w;
        @(posedge mclk);
        #1 ev = 6'h00;
        wr = 1'b0;
    endtask
    // Answer stands only in the cycle after the sampling edge
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        addr = a;
        rd = 1'b1;
        @(posedge mclk);
        #1 compares++;
        if (rvalid !== 1'b1 || rdata !== exp) begin
            error_cnt++;
            $display("MISMATCH rdata %h expected %h seen %h", a, exp, rdata);
        end
        // Pin copies lag the status bits by one edge, so they agree here
        if (a == 12'h16A && {pend, dirty} !== exp[1:0]) begin
            error_cnt++;
            $display("MISMATCH pins expected %h seen %h", exp[1:0],
                {pend, dirty});
        end
        rd = 1'b0;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        rd_chk(12'h16A, 32'h2);
        pulse(6'h08, 1'b0);
        rd_chk(12'h16A, 32'h0);
        rd_chk(12'h16C, 32'h077F0011);
        addr = 12'h16C;
        pulse(6'h00, 1'b1);
        rd_chk(12'h16C, 32'h077F0011);
        addr = 12'h16A;
        pulse(6'h00, 1'b1);
        rd_chk(12'h16A, 32'h0);
        pulse(6'h04, 1'b0);
        rd_chk(12'h16A, 32'h1);
        pulse(6'h01, 1'b0);
        rd_chk(12'h16A, 32'h1);
        pulse(6'h02, 1'b0);
        pulse(6'h01, 1'b0);
        rd_chk(12'h16A, 32'h0);
        pulse(6'h20, 1'b0);
        rd_chk(12'h16A, 32'h2);
        pulse(6'h08, 1'b0);
        pulse(6'h10, 1'b0);
        rd_chk(12'h16A, 32'h2);
        rd_chk(12'h170, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
